// file: design/cms_pkg.sv
// package for the clock multiplier and core clock selection block
// assumes one 100 MHz sys_clk; oscillator edges arrive as one-cycle ticks
package cms_pkg;

  // clock rate and timing figures
  localparam int unsigned SYS_CLK_KHZ        = 100000;
  localparam int unsigned FCM_MIN_KHZ        = 1600;
  localparam int unsigned SLOW_PERIOD_CYC    = SYS_CLK_KHZ / FCM_MIN_KHZ;
  localparam int unsigned LOCK_TIME_NS       = 10000;
  localparam int unsigned LOCK_CYC           = (LOCK_TIME_NS * (SYS_CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned BURST_SPACING_CYC  = 2;
  localparam int unsigned MULT_FACTOR        = 4;

  // register map
  localparam logic [7:0] MULT_CTRL_ADDR      = 8'hab;
  localparam logic [7:0] MULT_CTRL_RESET     = 8'h00;
  localparam int unsigned ENABLE_BIT         = 7;
  localparam int unsigned INIT_BIT           = 6;
  localparam int unsigned READY_BIT          = 5;
  localparam int unsigned SCALE_LSB          = 2;
  localparam int unsigned SCALE_MSB          = 4;
  localparam int unsigned SOURCE_LSB         = 0;
  localparam int unsigned SOURCE_MSB         = 1;

  // multiplier input source codes
  localparam logic [1:0] SRC_INT_HALF        = 2'h0;
  localparam logic [1:0] SRC_EXT_HALF        = 2'h1;
  localparam logic [1:0] SRC_EXT_FULL        = 2'h2;

  // core clock source codes
  localparam logic [1:0] CORE_SRC_INT        = 2'h0;
  localparam logic [1:0] CORE_SRC_EXT        = 2'h1;
  localparam logic [1:0] CORE_SRC_RTC        = 2'h2;
  localparam logic [1:0] CORE_SRC_MULT       = 2'h3;

  // special-function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cms_sfr_req_t;

  // oscillator rising-edge ticks
  typedef struct packed {
    logic int_osc;
    logic ext_osc;
    logic rtc_osc;
  } cms_osc_ticks_t;

  typedef enum logic [1:0] {
    LOCK_OFF,
    LOCK_WAIT,
    LOCK_WAIT_INIT,
    LOCK_DONE
  } cms_lock_state_t;

endpackage

// file: design/cms_scaler.sv
// pulse swallower: passes 2 of every n pulses, or all of them
// assumes in_tick is a one-cycle pulse train on sys_clk
`timescale 1ns/1ps
module cms_scaler
  import cms_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // control
  input  wire logic [2:0] scale_sel,
  // pulses
  input  wire logic       in_tick,
  output logic            out_tick
);

  logic [2:0] phase_ff;
  logic [2:0] nxt_phase;
  logic [2:0] modulus;
  logic       pass_all;
  logic       pass_now;

  // codes 000..010 pass all; code n from 011 passes 2 of every n: 2/3 up to 2/7
  assign pass_all  = (scale_sel < 3'h3);
  assign modulus   = scale_sel;
  assign pass_now  = pass_all || (phase_ff < 3'h2);
  assign nxt_phase = (phase_ff == modulus - 3'h1) ? 3'h0 : phase_ff + 3'h1;
  // duty is uneven for every modulus from 3 to 7, as the swallowed pulses are not spread
  assign out_tick  = in_tick && pass_now;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_ff <= 3'h0;
    else if (in_tick && !pass_all)
      phase_ff <= nxt_phase;
  end

endmodule

// file: design/cms_clock_ctrl.sv
// clock multiplier and core clock source selection
// assumes oscillator edges arrive as one-cycle ticks synchronous to sys_clk;
// register access is the special-function register strobe port
`timescale 1ns/1ps
module cms_clock_ctrl
  import cms_pkg::*;
#(
  parameter int unsigned PERIOD_W = 16
)
(
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           reset_n,
  // register access
  input  wire cms_sfr_req_t   sfr_req,
  output logic [7:0]          sfr_rdata,
  // oscillators
  input  wire cms_osc_ticks_t osc_ticks,
  input  wire logic           ext_osc_settled,
  // core clock selection
  input  wire logic [1:0]     core_clock_source_sel,
  // clock outputs
  output logic                core_clock_tick,
  output logic                mult_clock_tick,
  output logic                counter_array_ext_tick,
  // status
  output logic                crystal_valid_flag
);

  // control register fields
  logic                  mult_enable_ff;
  logic [2:0]            mult_scale_sel_ff;
  logic [1:0]            mult_source_sel_ff;
  logic                  mult_lock_ready;
  logic [7:0]            rdata_ff;
  logic                  ctrl_hit_wr;
  logic                  ctrl_hit_rd;
  logic                  init_cmd;
  logic [7:0]            ctrl_view;
  logic                  enable_wr;
  logic                  nxt_mult_enable;
  logic [2:0]            nxt_mult_scale_sel;
  logic [1:0]            nxt_mult_source_sel;
  logic [7:0]            nxt_rdata;

  // input selection
  logic                  int_half_ff;
  logic                  ext_half_ff;
  logic                  mult_in_tick;
  logic                  nxt_int_half;
  logic                  nxt_ext_half;

  // times-four generator
  logic [PERIOD_W-1:0]   period_cnt_ff;
  logic [PERIOD_W-1:0]   spacing_ff;
  logic [PERIOD_W-1:0]   gap_cnt_ff;
  logic [2:0]            pulses_left_ff;
  logic                  seen_edge_ff;
  logic [PERIOD_W-1:0]   nxt_spacing;
  logic [PERIOD_W-1:0]   nxt_period_cnt;
  logic [PERIOD_W-1:0]   nxt_gap_cnt;
  logic [2:0]            nxt_pulses_left;
  logic                  slow_input;
  logic                  gap_done;
  logic                  x4_tick;
  logic                  scaled_tick;

  // lock sequencing
  cms_lock_state_t       lock_state_ff;
  cms_lock_state_t       nxt_lock_state;
  logic [15:0]           lock_cnt_ff;
  logic                  lock_cnt_done;
  logic [15:0]           nxt_lock_cnt;

  // core clock and crystal flag
  logic                  core_tick_ff;
  logic                  crystal_valid_ff;
  logic                  core_tick_sel;

  function automatic logic src_tick(input logic [1:0] sel, input logic ih, input logic eh, input logic ef,
                                    input logic ifull);
    case (sel)
      SRC_INT_HALF: src_tick = ih;
      SRC_EXT_HALF: src_tick = eh;
      SRC_EXT_FULL: src_tick = ef;
      default:      src_tick = ifull;
    endcase
  endfunction

  // register decode
  assign ctrl_hit_wr = sfr_req.wr && (sfr_req.addr == MULT_CTRL_ADDR);
  assign ctrl_hit_rd = sfr_req.rd && (sfr_req.addr == MULT_CTRL_ADDR);
  assign enable_wr   = ctrl_hit_wr && sfr_req.wdata[ENABLE_BIT];
  // a write rewrites enable too, so init only counts when it carries enable
  assign init_cmd    = enable_wr && sfr_req.wdata[INIT_BIT];
  assign mult_lock_ready = (lock_state_ff == LOCK_DONE);
  // init bit is a command and reads back as zero
  assign ctrl_view   = {mult_enable_ff, 1'b0, mult_lock_ready, mult_scale_sel_ff, mult_source_sel_ff};
  assign sfr_rdata   = rdata_ff;

  // a write replaces all stored fields at once; init and ready are not stored
  assign nxt_mult_enable     = ctrl_hit_wr ? sfr_req.wdata[ENABLE_BIT] : mult_enable_ff;
  assign nxt_mult_scale_sel  = ctrl_hit_wr ? sfr_req.wdata[SCALE_MSB:SCALE_LSB] : mult_scale_sel_ff;
  assign nxt_mult_source_sel = ctrl_hit_wr ? sfr_req.wdata[SOURCE_MSB:SOURCE_LSB] : mult_source_sel_ff;
  // only a read moves the read data, so it stands between reads
  assign nxt_rdata           = ctrl_hit_rd ? ctrl_view : (sfr_req.rd ? 8'h00 : rdata_ff);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mult_enable_ff     <= MULT_CTRL_RESET[ENABLE_BIT];
      mult_scale_sel_ff  <= MULT_CTRL_RESET[SCALE_MSB:SCALE_LSB];
      mult_source_sel_ff <= MULT_CTRL_RESET[SOURCE_MSB:SOURCE_LSB];
    end
    else
    begin
      mult_enable_ff     <= nxt_mult_enable;
      mult_scale_sel_ff  <= nxt_mult_scale_sel;
      mult_source_sel_ff <= nxt_mult_source_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  // halving stages: pass every other oscillator edge
  assign nxt_int_half = osc_ticks.int_osc ? !int_half_ff : int_half_ff;
  assign nxt_ext_half = osc_ticks.ext_osc ? !ext_half_ff : ext_half_ff;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_half_ff <= 1'b0;
      ext_half_ff <= 1'b0;
    end
    else
    begin
      int_half_ff <= nxt_int_half;
      ext_half_ff <= nxt_ext_half;
    end
  end

  assign mult_in_tick = mult_enable_ff &&
                        src_tick(mult_source_sel_ff, osc_ticks.int_osc && int_half_ff,
                                 osc_ticks.ext_osc && ext_half_ff, osc_ticks.ext_osc,
                                 osc_ticks.int_osc);

  // times-four: measure input period, spread four pulses across it; a slow or first input edge gets a burst 2 cycles apart
  assign slow_input  = (period_cnt_ff > PERIOD_W'(SLOW_PERIOD_CYC));
  assign nxt_spacing = (slow_input || !seen_edge_ff) ? PERIOD_W'(BURST_SPACING_CYC) :
                       ((period_cnt_ff >> 2) == '0) ? PERIOD_W'(1) : (period_cnt_ff >> 2);
  assign gap_done    = (gap_cnt_ff >= spacing_ff - PERIOD_W'(1));
  assign x4_tick     = mult_in_tick || ((pulses_left_ff != 3'h0) && gap_done);

  // restart on every input edge; saturate so a stopped input reads as slow
  assign nxt_period_cnt  = (mult_in_tick || !mult_enable_ff) ? PERIOD_W'(1) :
                           ((period_cnt_ff != '1) ? period_cnt_ff + PERIOD_W'(1) : period_cnt_ff);
  assign nxt_gap_cnt     = gap_done ? '0 : gap_cnt_ff + PERIOD_W'(1);
  assign nxt_pulses_left = gap_done ? pulses_left_ff - 3'h1 : pulses_left_ff;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      period_cnt_ff <= '0;
    else
      period_cnt_ff <= nxt_period_cnt;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spacing_ff     <= PERIOD_W'(1);
      gap_cnt_ff     <= '0;
      pulses_left_ff <= 3'h0;
      seen_edge_ff   <= 1'b0;
    end
    else if (!mult_enable_ff)
    begin
      pulses_left_ff <= 3'h0;
      seen_edge_ff   <= 1'b0;
    end
    else if (mult_in_tick)
    begin
      // a fresh edge restarts the group, so no edge is lost to a pending burst
      spacing_ff     <= nxt_spacing;
      gap_cnt_ff     <= '0;
      pulses_left_ff <= 3'(MULT_FACTOR - 1);
      seen_edge_ff   <= 1'b1;
    end
    else if (pulses_left_ff != 3'h0)
    begin
      gap_cnt_ff     <= nxt_gap_cnt;
      pulses_left_ff <= nxt_pulses_left;
    end
  end

  cms_scaler u_scaler (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .scale_sel (mult_scale_sel_ff),
    .in_tick   (x4_tick),
    .out_tick  (scaled_tick)
  );

  // lock sequencing: enable, then init, then a fixed settling time
  // the fixed count stands in for analog settling, which the logic cannot observe
  assign lock_cnt_done = (lock_cnt_ff >= 16'(LOCK_CYC - 1));

  // every init restarts the count, so a re-init waits the full settling time unless it lands in the last waiting cycle
  assign nxt_lock_cnt  = (nxt_lock_state != LOCK_WAIT || init_cmd) ? 16'h0000 :
                         (lock_cnt_done ? lock_cnt_ff : lock_cnt_ff + 16'h0001);

  always_comb
  begin
    nxt_lock_state = lock_state_ff;
    case (lock_state_ff)
      LOCK_OFF:       nxt_lock_state = init_cmd ? LOCK_WAIT : (enable_wr ? LOCK_WAIT_INIT : LOCK_OFF);
      LOCK_WAIT:      nxt_lock_state = lock_cnt_done ? LOCK_DONE : LOCK_WAIT;
      LOCK_WAIT_INIT: nxt_lock_state = init_cmd ? LOCK_WAIT : LOCK_WAIT_INIT;
      LOCK_DONE:      nxt_lock_state = init_cmd ? LOCK_WAIT : LOCK_DONE;
      default:        nxt_lock_state = LOCK_OFF;
    endcase
    if (ctrl_hit_wr && !sfr_req.wdata[ENABLE_BIT])
      nxt_lock_state = LOCK_OFF;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lock_state_ff <= LOCK_OFF;
    else
      lock_state_ff <= nxt_lock_state;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      lock_cnt_ff <= 16'h0000;
    else
      lock_cnt_ff <= nxt_lock_cnt;
  end

  // unlocked multiplier output is held off so the core never sees it
  assign mult_clock_tick = scaled_tick && mult_lock_ready;

  // core clock selection; internal oscillator needs no start-up wait
  // the switch is immediate, so software must only pick a source that already runs
  always_comb
  begin
    case (core_clock_source_sel)
      CORE_SRC_INT:  core_tick_sel = osc_ticks.int_osc;
      CORE_SRC_EXT:  core_tick_sel = osc_ticks.ext_osc;
      CORE_SRC_RTC:  core_tick_sel = osc_ticks.rtc_osc;
      CORE_SRC_MULT: core_tick_sel = mult_clock_tick;
      default:       core_tick_sel = osc_ticks.int_osc;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_tick_ff     <= 1'b0;
      crystal_valid_ff <= 1'b0;
    end
    else
    begin
      core_tick_ff     <= core_tick_sel;
      crystal_valid_ff <= ext_osc_settled;
    end
  end

  assign core_clock_tick        = core_tick_ff;
  assign counter_array_ext_tick = osc_ticks.ext_osc;
  assign crystal_valid_flag     = crystal_valid_ff;

endmodule

// file: design/cms_unused_guard.sv
// holds no logic; the block lives in cms_clock_ctrl.sv and cms_scaler.sv

// file: dv/cms_clock_ctrl_properties.sv
// concurrent checks on the clock multiplier and core clock select ports
// assumes it is bound onto cms_clock_ctrl; everything is in the sys_clk domain
`timescale 1ns/1ps
module cms_clock_ctrl_properties
  import cms_pkg::*;
#(
  parameter int unsigned PERIOD_W = 16
)
(
  // clock and reset
  input wire logic           sys_clk,
  input wire logic           reset_n,
  // register access
  input wire cms_sfr_req_t   sfr_req,
  input wire logic [7:0]     sfr_rdata,
  // oscillators and selection
  input wire cms_osc_ticks_t osc_ticks,
  input wire logic           ext_osc_settled,
  input wire logic [1:0]     core_clock_source_sel,
  // outputs
  input wire logic           core_clock_tick,
  input wire logic           mult_clock_tick,
  input wire logic           counter_array_ext_tick,
  input wire logic           crystal_valid_flag
);
  wire logic ctrl_hit = sfr_req.addr == MULT_CTRL_ADDR;
  wire logic sel_tick = (core_clock_source_sel == CORE_SRC_INT) ? osc_ticks.int_osc :
                        (core_clock_source_sel == CORE_SRC_EXT) ? osc_ticks.ext_osc :
                        (core_clock_source_sel == CORE_SRC_RTC) ? osc_ticks.rtc_osc : mult_clock_tick;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ctrl_wr;
    sfr_req.wr && ctrl_hit;
  endsequence
  // lock takes far longer than eight cycles, so no pulse may leak meanwhile
  sequence s_quiet;
    !mult_clock_tick [*8];
  endsequence

  a_ext_tick_copy: assert property (counter_array_ext_tick == osc_ticks.ext_osc)
    else $error("counter array tick differs from external tick");
  a_xtal_flag_follow: assert property ($past(reset_n) |-> crystal_valid_flag == $past(ext_osc_settled))
    else $error("crystal valid flag does not follow settle input");
  a_core_tick_follow: assert property ($past(reset_n) |-> core_clock_tick == $past(sel_tick))
    else $error("core tick is not the selected source tick");
  a_core_ext_only: assert property (osc_ticks.ext_osc && core_clock_source_sel == CORE_SRC_EXT |=> core_clock_tick)
    else $error("external tick missing on core clock");
  a_core_int_now: assert property (osc_ticks.int_osc && core_clock_source_sel == CORE_SRC_INT |=> core_clock_tick)
    else $error("internal tick missing on core clock");
  a_mult_off_quiet: assert property (s_ctrl_wr ##0 !sfr_req.wdata[ENABLE_BIT] |=> s_quiet)
    else $error("multiplier pulses after disable");
  a_init_lock_wait: assert property (s_ctrl_wr ##0 (sfr_req.wdata[ENABLE_BIT] && sfr_req.wdata[INIT_BIT]) |=> s_quiet)
    else $error("multiplier pulses before lock");
  a_init_reads_zero: assert property (sfr_req.rd |=> !sfr_rdata[INIT_BIT])
    else $error("init bit reads one");
  a_unmapped_zero: assert property (sfr_req.rd && !ctrl_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
endmodule

bind cms_clock_ctrl cms_clock_ctrl_properties #(.PERIOD_W(PERIOD_W)) cms_clock_ctrl_properties_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .osc_ticks(osc_ticks),
  .ext_osc_settled(ext_osc_settled), .core_clock_source_sel(core_clock_source_sel),
  .core_clock_tick(core_clock_tick), .mult_clock_tick(mult_clock_tick),
  .counter_array_ext_tick(counter_array_ext_tick), .crystal_valid_flag(crystal_valid_flag));

// file: dv/cms_clock_ctrl_tb.sv
// self-checking bench for the clock multiplier and core clock select block
// assumes the checker is bound in; oscillator edges are modelled as sys_clk ticks
`timescale 1ns/1ps
module cms_clock_ctrl_tb
  import cms_pkg::*;
;
  localparam int INT_P = 8;
  localparam int EXT_P = 12;
  localparam int RTC_P = 40;
  localparam int WIN   = 1680;

  logic           sys_clk;
  logic           reset_n;
  cms_sfr_req_t   sfr_req;
  logic [7:0]     sfr_rdata;
  cms_osc_ticks_t osc_ticks;
  logic           ext_osc_settled;
  logic [1:0]     core_clock_source_sel;
  logic           core_clock_tick;
  logic           mult_clock_tick;
  logic           counter_array_ext_tick;
  logic           crystal_valid_flag;
  logic [7:0]     rdata_seen;
  logic           counting;
  int             mismatches;
  int             checks;
  int             cyc;
  int             int_p;
  int             mcnt;
  int             ccnt;

  cms_clock_ctrl #(.PERIOD_W(16)) cms_clock_ctrl_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .osc_ticks(osc_ticks),
    .ext_osc_settled(ext_osc_settled), .core_clock_source_sel(core_clock_source_sel),
    .core_clock_tick(core_clock_tick), .mult_clock_tick(mult_clock_tick),
    .counter_array_ext_tick(counter_array_ext_tick), .crystal_valid_flag(crystal_valid_flag));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // oscillators as periodic one-cycle ticks; int_p is slowed for the burst case
  always @(posedge sys_clk)
  begin
    #1;
    cyc = cyc + 1;
    osc_ticks = {(cyc % int_p) == 0, (cyc % EXT_P) == 0, (cyc % RTC_P) == 0};
  end

  // sampled before this edge's updates land, so each cycle counts once
  always @(posedge sys_clk)
    if (counting)
    begin
      mcnt = mcnt + mult_clock_tick;
      ccnt = ccnt + core_clock_tick;
    end

  task automatic results;
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // window edges and scaler phase may shift a count by a few pulses
  task automatic near(input int seen, input int exp);
    check(16'((seen - exp) <= 4 && (exp - seen) <= 4), 16'h1);
  endtask

  // one strobe cycle; a read leaves its data in rdata_seen
  task automatic sfr_io(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sfr_req = {w, !w, a, d};
    @(posedge sys_clk);
    #1;
    sfr_req = {2'b00, a, d};
    rdata_seen = sfr_rdata;
  endtask

  task automatic count(input int len);
    mcnt = 0;
    ccnt = 0;
    counting = 1'b1;
    repeat (len) @(posedge sys_clk);
    #1;
    counting = 1'b0;
  endtask

  task automatic run(input logic [1:0] src, input logic [2:0] scl, input logic [1:0] sel, input int em, input int ec);
    logic [7:0] f;
    int         n;
    f = {3'b000, scl, src};
    core_clock_source_sel = sel;
    sfr_io(1'b1, MULT_CTRL_ADDR, 8'h00);
    sfr_io(1'b1, MULT_CTRL_ADDR, f);
    sfr_io(1'b1, MULT_CTRL_ADDR, f | 8'ha0);
    sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
    check(16'(rdata_seen), 16'(f | 8'h80));
    repeat (500) @(posedge sys_clk);
    sfr_io(1'b1, MULT_CTRL_ADDR, f | 8'hc0);
    repeat (985) @(posedge sys_clk);
    sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
    check(16'(rdata_seen), 16'(f | 8'h80));
    n = 0;
    while (rdata_seen[READY_BIT] !== 1'b1 && n < 20)
    begin
      sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
      n++;
    end
    check(16'(rdata_seen), 16'(f | 8'ha0));
    repeat (50) @(posedge sys_clk);
    count(WIN);
    near(mcnt, em);
    near(ccnt, ec);
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    results();
  end

  initial
  begin
    logic [1:0] src;
    logic [1:0] sel;
    logic [2:0] scl;
    int         em;
    int         ec;
    int         per;
    int         n;
    reset_n = 1'b0;
    sfr_req = '0;
    osc_ticks = '0;
    ext_osc_settled = 1'b0;
    core_clock_source_sel = CORE_SRC_INT;
    counting = 1'b0;
    {mismatches, checks, cyc, mcnt, ccnt} = '0;
    int_p = INT_P;
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
    check(16'(rdata_seen), 16'(MULT_CTRL_RESET));
    check(16'(crystal_valid_flag), 16'h0);
    ext_osc_settled = 1'b1;
    @(posedge sys_clk);
    #1;
    check(16'(crystal_valid_flag), 16'h1);
    for (int i = 0; i < 11; i++)
    begin
      src = (i < 4) ? 2'(i) : 2'h0;
      scl = (i < 4) ? 3'h0 : 3'(i - 3);
      per = (src == 2'h0) ? 2 * INT_P : (src == 2'h1) ? 2 * EXT_P : (src == 2'h2) ? EXT_P : INT_P;
      em = 4 * WIN / per;
      if (scl >= 3'h3)
        em = em * 2 / int'(scl);
      sel = 2'(i);
      ec = (sel == 2'h0) ? WIN / INT_P : (sel == 2'h1) ? WIN / EXT_P : (sel == 2'h2) ? WIN / RTC_P : em;
      run(src, scl, sel, em, ec);
    end
    int_p = 80;
    run(2'h3, 3'h0, CORE_SRC_INT, 4 * WIN / 80, WIN / 80);
    @(negedge sys_clk iff osc_ticks.int_osc);
    n = mult_clock_tick;
    repeat (11)
    begin
      @(negedge sys_clk);
      n = n + mult_clock_tick;
    end
    check(16'(n), 16'h4);
    sfr_io(1'b1, MULT_CTRL_ADDR, 8'h43);
    sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
    check(16'(rdata_seen), 16'h03);
    repeat (1010) @(posedge sys_clk);
    count(200);
    check(16'(mcnt), 16'h0);
    sfr_io(1'b1, 8'haa, 8'hff);
    sfr_io(1'b0, 8'haa, 8'h00);
    check(16'(rdata_seen), 16'h00);
    sfr_io(1'b0, MULT_CTRL_ADDR, 8'h00);
    check(16'(rdata_seen), 16'h03);
    results();
  end
endmodule
